// *** common/hmb_pkg.sv ***
// Constants and carrier types for the host mailbox command engine.
// Assumes one 40 MHz clock and an asynchronous active-low reset.
//
// Summary of operation
// - Read-buffer command is code 0 with address low/high in mailbox registers 1 and 2.
// - Buffer read returns status in reg0, attribute byte in reg2, data in reg3.
// - Command 1 writes reg3 into buffer at reg1/reg2 address; status returned.
// - Command 2 returns status, cursor address low/high, auxiliary status.
// - Command 3 clears status bits masked by reg3; only bits 7,6,3,1,0.
// - Status returned by the clear command is the value after clearing.
// - Command 4 sends reg3 key code and clears key-buffer-empty bit 5.
// - Command 5 sends pen row from reg1 and field id from reg2.
// - Command 6 presents power-on-reset to control unit; status returned.
// - Command 7 loads trigger data from reg1 and trigger mask from reg2.
// - Trigger bit sets on address match and masked data match.
// - Command 8 loads trigger address from reg1/reg2 and clears trigger bit.
// - Command 9 loads attention mask from reg3; status returned.
// - Attention flag sets when a status bit rises with its mask bit set.
// - Set-terminal-type stores a changed type and issues power-on-reset only when the type changes; status returned.
// - Command C returns attribute page, variable page, current terminal type.
// - Command E returns revision BCD low, high and OEM number.
// - Any host write to the request address sets the command request flag.
// - Engine clears the request flag, executes, writes results back.
// - Flag read gives attention in bit 7, request in bit 6; write clears attention.

package hmb_pkg;

   // Command codes, low nibble of mailbox register 0.
   localparam logic [3:0] CMD_RD_BUF   = 4'h0;
   localparam logic [3:0] CMD_WR_BUF   = 4'h1;
   localparam logic [3:0] CMD_RD_STAT  = 4'h2;
   localparam logic [3:0] CMD_CLR_STAT = 4'h3;
   localparam logic [3:0] CMD_KEY      = 4'h4;
   localparam logic [3:0] CMD_PEN      = 4'h5;
   localparam logic [3:0] CMD_POR      = 4'h6;
   localparam logic [3:0] CMD_TRG_DATA = 4'h7;
   localparam logic [3:0] CMD_TRG_ADDR = 4'h8;
   localparam logic [3:0] CMD_ATTN_MSK = 4'h9;
   localparam logic [3:0] CMD_SET_TYPE = 4'hA;
   localparam logic [3:0] CMD_RD_INFO  = 4'hC;
   localparam logic [3:0] CMD_REV_ID   = 4'hE;

   // Main status bit positions.
   localparam int ST_AUX_CHG  = 7;
   localparam int ST_TRIGGER  = 6;
   localparam int ST_KEY_EMPT = 5;
   localparam int ST_CU_RESET = 3;
   localparam int ST_BUF_MOD  = 1;
   localparam int ST_CUR_LOAD = 0;
   localparam logic [7:0] ST_CLEARABLE = 8'hCB;

   // Flag register bit positions.
   localparam int FLG_ATTN = 7;
   localparam int FLG_REQ  = 6;

   // Reset values.
   localparam logic [7:0]  MAIN_STAT_RST = 8'h20;
   localparam logic [7:0]  ATTN_MSK_RST  = 8'h00;
   localparam logic [7:0]  TERM_TYPE_RST = 8'h00;
   localparam logic [12:0] TRG_ADDR_RST  = 13'h0000;

   // Fixed information answers; the revision and OEM values are arbitrary.
   localparam logic [7:0] ATTR_PAGE  = 8'h10;
   localparam logic [7:0] VAR_PAGE   = 8'h18;
   localparam logic [7:0] REV_LO_BCD = 8'h00;
   localparam logic [7:0] REV_HI_BCD = 8'h01;
   localparam logic [7:0] OEM_NUMBER = 8'h00;

   // Four mailbox bytes travel together.
   typedef struct packed {
      logic [7:0] reg3;
      logic [7:0] reg2;
      logic [7:0] reg1;
      logic [7:0] reg0;
   } hmb_mbox_s;

   // Request towards the display buffer.
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [12:0] addr;
      logic [7:0]  data;
   } hmb_buf_req_s;

endpackage : hmb_pkg

// *** core/hmb_engine.sv ***
// Host mailbox command engine: mailbox, flags, command execution, trigger and attention.
// Assumes a buffer memory answering reads in the cycle the request stands, and host
// strobes that are synchronous one-cycle pulses on ref_clk.
`timescale 1ns/1ps
`default_nettype none

module hmb_engine (
   input  wire logic                  ref_clk,
   input  wire logic                  arst_n,
   input  wire logic                  mbox_wr,
   input  wire logic [1:0]            mbox_wr_idx,
   input  wire logic [7:0]            mbox_wr_data,
   input  wire logic                  req_wr,
   input  wire logic                  flag_wr,
   input  wire logic [7:0]            buf_rd_data,
   input  wire logic [7:0]            attr_rd_data,
   input  wire logic [7:0]            aux_status,
   input  wire logic [12:0]           cursor_addr,
   input  wire logic                  cu_reset_evt,
   input  wire logic                  aux_chg_evt,
   input  wire logic                  cursor_load_evt,
   output hmb_pkg::hmb_mbox_s         mailbox_q,
   output logic [7:0]                 flag_reg_q,
   output hmb_pkg::hmb_buf_req_s      buf_req_q,
   output logic                       key_send_q,
   output logic [7:0]                 key_code_q,
   output logic                       pen_send_q,
   output logic [7:0]                 pen_row_q,
   output logic [7:0]                 pen_field_q,
   output logic                       por_send_q,
   output logic [7:0]                 term_type_q,
   output logic [7:0]                 main_stat_q
);

   typedef enum logic [1:0] {HMB_IDLE, HMB_EXEC, HMB_RDWAIT} hmb_state_e;

   hmb_state_e  state_q;
   logic        req_q;
   logic        attn_q;
   logic [7:0]  attn_msk_q;
   logic [7:0]  trg_data_q;
   logic [7:0]  trg_msk_q;
   logic [12:0] trg_addr_q;
   logic [7:0]  stat_d;
   logic [7:0]  stat_set;
   logic [7:0]  stat_prev_q;
   logic [12:0] mb_addr;
   logic        buf_wr_match;
   logic        cmd_start;

   assign mb_addr   = {mailbox_q.reg2[4:0], mailbox_q.reg1};
   assign cmd_start = (state_q == HMB_IDLE) && req_q;

   // Trigger compares each buffer write against the loaded address and masked data.
   assign buf_wr_match = buf_req_q.valid && buf_req_q.write && (buf_req_q.addr == trg_addr_q)
                         && (((buf_req_q.data ^ trg_data_q) & trg_msk_q) == 8'h00);

   ////////////////////////////////////////////////////////////////////////////
   // Command request flag: a host write sets it, the engine clears it on pickup.
   // The set wins so that a request arriving during pickup is not lost.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         req_q <= 1'b0;
      end else if (req_wr) begin
         req_q <= 1'b1;
      end else if (cmd_start) begin
         req_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Engine sequencing: idle polls the flag, execute one cycle, buffer reads wait.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= HMB_IDLE;
      end else begin
         unique case (state_q)
            HMB_IDLE: begin
               if (req_q) begin
                  state_q <= HMB_EXEC;
               end
            end
            HMB_EXEC: begin
               state_q <= (mailbox_q.reg0[3:0] == hmb_pkg::CMD_RD_BUF) ? HMB_RDWAIT : HMB_IDLE;
            end
            HMB_RDWAIT: begin
               state_q <= HMB_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status bits raised by hardware this cycle; kept as one vector so a clear can be checked against it.
   always_comb begin
      stat_set                       = 8'h00;
      stat_set[hmb_pkg::ST_TRIGGER]  = buf_wr_match;
      stat_set[hmb_pkg::ST_BUF_MOD]  = buf_req_q.valid && buf_req_q.write;
      stat_set[hmb_pkg::ST_CU_RESET] = cu_reset_evt;
      stat_set[hmb_pkg::ST_AUX_CHG]  = aux_chg_evt;
      stat_set[hmb_pkg::ST_CUR_LOAD] = cursor_load_evt;
   end

   // Next main status: hardware events set bits, commands clear them; sets win.
   always_comb begin
      stat_d = main_stat_q;
      if (state_q == HMB_EXEC) begin
         unique case (mailbox_q.reg0[3:0])
            hmb_pkg::CMD_CLR_STAT: stat_d = stat_d & ~(mailbox_q.reg3 & hmb_pkg::ST_CLEARABLE);
            hmb_pkg::CMD_KEY:      stat_d[hmb_pkg::ST_KEY_EMPT] = 1'b0;
            hmb_pkg::CMD_TRG_ADDR: stat_d[hmb_pkg::ST_TRIGGER] = 1'b0;
            default:               stat_d = main_stat_q;
         endcase
      end
      // A set in the same cycle as a clear must win, or an event would be lost.
      stat_d = stat_d | stat_set;
   end

   // Main status register and its previous value for rise detection.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         main_stat_q <= hmb_pkg::MAIN_STAT_RST;
         stat_prev_q <= hmb_pkg::MAIN_STAT_RST;
      end else begin
         main_stat_q <= stat_d;
         stat_prev_q <= main_stat_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Attention flag: a masked rising status bit sets it, a flag write clears it.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         attn_q <= 1'b0;
      end else if (|(main_stat_q & ~stat_prev_q & attn_msk_q)) begin
         attn_q <= 1'b1;
      end else if (flag_wr) begin
         attn_q <= 1'b0;
      end
   end

   // Flag register image; low six bits read as zero.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_reg_q <= 8'h00;
      end else begin
         flag_reg_q <= {attn_q, req_q, 6'b00_0000};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers loaded by commands.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         trg_data_q  <= 8'h00;
         trg_msk_q   <= 8'h00;
         trg_addr_q  <= hmb_pkg::TRG_ADDR_RST;
         attn_msk_q  <= hmb_pkg::ATTN_MSK_RST;
         term_type_q <= hmb_pkg::TERM_TYPE_RST;
      end else if (state_q == HMB_EXEC) begin
         unique case (mailbox_q.reg0[3:0])
            hmb_pkg::CMD_TRG_DATA: begin
               trg_data_q <= mailbox_q.reg1;
               trg_msk_q  <= mailbox_q.reg2;
            end
            hmb_pkg::CMD_TRG_ADDR: trg_addr_q <= mb_addr;
            hmb_pkg::CMD_ATTN_MSK: attn_msk_q <= mailbox_q.reg3;
            hmb_pkg::CMD_SET_TYPE: begin
               if (mailbox_q.reg3 != term_type_q) begin
                  term_type_q <= mailbox_q.reg3;
               end
            end
            default: term_type_q <= term_type_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One-cycle commands towards the buffer and the control-unit link.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         buf_req_q   <= '0;
         key_send_q  <= 1'b0;
         key_code_q  <= 8'h00;
         pen_send_q  <= 1'b0;
         pen_row_q   <= 8'h00;
         pen_field_q <= 8'h00;
         por_send_q  <= 1'b0;
      end else begin
         buf_req_q.valid <= 1'b0;
         key_send_q      <= 1'b0;
         pen_send_q      <= 1'b0;
         por_send_q      <= 1'b0;
         if (state_q == HMB_EXEC) begin
            unique case (mailbox_q.reg0[3:0])
               hmb_pkg::CMD_RD_BUF: begin
                  buf_req_q <= '{valid: 1'b1, write: 1'b0, addr: mb_addr, data: 8'h00};
               end
               hmb_pkg::CMD_WR_BUF: begin
                  buf_req_q <= '{valid: 1'b1, write: 1'b1, addr: mb_addr, data: mailbox_q.reg3};
               end
               hmb_pkg::CMD_KEY: begin
                  key_send_q <= 1'b1;
                  key_code_q <= mailbox_q.reg3;
               end
               hmb_pkg::CMD_PEN: begin
                  pen_send_q  <= 1'b1;
                  pen_row_q   <= mailbox_q.reg1;
                  pen_field_q <= mailbox_q.reg2;
               end
               hmb_pkg::CMD_POR: por_send_q <= 1'b1;
               hmb_pkg::CMD_SET_TYPE: por_send_q <= (mailbox_q.reg3 != term_type_q);
               default: por_send_q <= 1'b0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mailbox: host writes load bytes; the engine writes results back.
   // Results use the post-update status so a clear is visible in the answer.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mailbox_q <= '0;
      end else if (state_q == HMB_EXEC) begin
         mailbox_q.reg0 <= stat_d;
         unique case (mailbox_q.reg0[3:0])
            hmb_pkg::CMD_RD_STAT: begin
               mailbox_q.reg1 <= cursor_addr[7:0];
               mailbox_q.reg2 <= {3'b000, cursor_addr[12:8]};
               mailbox_q.reg3 <= aux_status;
            end
            hmb_pkg::CMD_RD_INFO: begin
               mailbox_q.reg1 <= hmb_pkg::ATTR_PAGE;
               mailbox_q.reg2 <= hmb_pkg::VAR_PAGE;
               mailbox_q.reg3 <= term_type_q;
            end
            hmb_pkg::CMD_REV_ID: begin
               mailbox_q.reg1 <= hmb_pkg::REV_LO_BCD;
               mailbox_q.reg2 <= hmb_pkg::REV_HI_BCD;
               mailbox_q.reg3 <= hmb_pkg::OEM_NUMBER;
            end
            default: mailbox_q.reg1 <= mailbox_q.reg1;
         endcase
      end else if (state_q == HMB_RDWAIT) begin
         mailbox_q.reg0 <= stat_d;
         mailbox_q.reg2 <= attr_rd_data;
         mailbox_q.reg3 <= buf_rd_data;
      end else if (mbox_wr) begin
         unique case (mbox_wr_idx)
            2'd0: mailbox_q.reg0 <= mbox_wr_data;
            2'd1: mailbox_q.reg1 <= mbox_wr_data;
            2'd2: mailbox_q.reg2 <= mbox_wr_data;
            2'd3: mailbox_q.reg3 <= mbox_wr_data;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks kept beside the logic.
   property p_req_set;
      @(posedge ref_clk) disable iff (!arst_n) req_wr |=> req_q;
   endproperty
   a_req_set: assert property (p_req_set) else $error("request flag not set");

   property p_req_taken;
      @(posedge ref_clk) disable iff (!arst_n)
         (state_q == HMB_IDLE && req_q && !req_wr) |=> (!req_q && state_q == HMB_EXEC);
   endproperty
   a_req_taken: assert property (p_req_taken) else $error("request not taken");

   property p_clear_after;
      @(posedge ref_clk) disable iff (!arst_n)
         (state_q == HMB_EXEC && mailbox_q.reg0[3:0] == hmb_pkg::CMD_CLR_STAT)
         |=> ((mailbox_q.reg0 & $past(mailbox_q.reg3 & hmb_pkg::ST_CLEARABLE & ~stat_set)) == 8'h00);
   endproperty
   a_clear_after: assert property (p_clear_after) else $error("cleared bit returned set");

   property p_key_empty;
      @(posedge ref_clk) disable iff (!arst_n)
         (state_q == HMB_EXEC && mailbox_q.reg0[3:0] == hmb_pkg::CMD_KEY)
         |=> (key_send_q && !main_stat_q[hmb_pkg::ST_KEY_EMPT]);
   endproperty
   a_key_empty: assert property (p_key_empty) else $error("key empty not cleared");

   property p_trigger;
      @(posedge ref_clk) disable iff (!arst_n) buf_wr_match |=> main_stat_q[hmb_pkg::ST_TRIGGER];
   endproperty
   a_trigger: assert property (p_trigger) else $error("trigger not set");

   property p_attn;
      @(posedge ref_clk) disable iff (!arst_n)
         (|(main_stat_q & ~stat_prev_q & attn_msk_q)) |=> ##1 flag_reg_q[hmb_pkg::FLG_ATTN];
   endproperty
   a_attn: assert property (p_attn) else $error("attention not raised");

   property p_flag_zero;
      @(posedge ref_clk) disable iff (!arst_n) flag_reg_q[5:0] == 6'h00;
   endproperty
   a_flag_zero: assert property (p_flag_zero) else $error("flag low bits nonzero");

   property p_read_done;
      @(posedge ref_clk) disable iff (!arst_n)
         (state_q == HMB_RDWAIT) |=> (mailbox_q.reg3 == $past(buf_rd_data)
                                      && mailbox_q.reg2 == $past(attr_rd_data));
   endproperty
   a_read_done: assert property (p_read_done) else $error("read result wrong");

   property p_type_por;
      @(posedge ref_clk) disable iff (!arst_n)
         (state_q == HMB_EXEC && mailbox_q.reg0[3:0] == hmb_pkg::CMD_SET_TYPE
          && mailbox_q.reg3 != term_type_q) |=> (por_send_q && term_type_q == $past(mailbox_q.reg3));
   endproperty
   a_type_por: assert property (p_type_por) else $error("terminal type change missed");

   property p_write_req;
      @(posedge ref_clk) disable iff (!arst_n)
         (state_q == HMB_EXEC && mailbox_q.reg0[3:0] == hmb_pkg::CMD_WR_BUF)
         |=> (buf_req_q.valid && buf_req_q.write && buf_req_q.addr == $past(mb_addr)
              && buf_req_q.data == $past(mailbox_q.reg3));
   endproperty
   a_write_req: assert property (p_write_req) else $error("buffer write request wrong");

   property p_status_cmd;
      @(posedge ref_clk) disable iff (!arst_n)
         (state_q == HMB_EXEC && mailbox_q.reg0[3:0] == hmb_pkg::CMD_RD_STAT)
         |=> (mailbox_q.reg1 == $past(cursor_addr[7:0]) && mailbox_q.reg3 == $past(aux_status));
   endproperty
   a_status_cmd: assert property (p_status_cmd) else $error("status answer wrong");

   property p_trg_addr;
      @(posedge ref_clk) disable iff (!arst_n)
         (state_q == HMB_EXEC && mailbox_q.reg0[3:0] == hmb_pkg::CMD_TRG_ADDR && !buf_wr_match)
         |=> (!main_stat_q[hmb_pkg::ST_TRIGGER] && trg_addr_q == $past(mb_addr));
   endproperty
   a_trg_addr: assert property (p_trg_addr) else $error("trigger address load wrong");

   property p_attn_mask;
      @(posedge ref_clk) disable iff (!arst_n)
         (state_q == HMB_EXEC && mailbox_q.reg0[3:0] == hmb_pkg::CMD_ATTN_MSK)
         |=> (attn_msk_q == $past(mailbox_q.reg3));
   endproperty
   a_attn_mask: assert property (p_attn_mask) else $error("attention mask not loaded");

   property p_undef;
      @(posedge ref_clk) disable iff (!arst_n)
         (state_q == HMB_EXEC && mailbox_q.reg0[3:0] inside {4'hB, 4'hD, 4'hF})
         |=> (mailbox_q.reg1 == $past(mailbox_q.reg1) && mailbox_q.reg2 == $past(mailbox_q.reg2)
              && mailbox_q.reg3 == $past(mailbox_q.reg3));
   endproperty
   a_undef: assert property (p_undef) else $error("undefined command touched arguments");

endmodule : hmb_engine

`default_nettype wire

// *** test/hmb_buf_model.sv ***
// Behavioural display buffer that stands on the far side of the engine's buffer port.
// Assumes single-cycle request pulses; a read answers while its request stands.
`timescale 1ns/1ps
`default_nettype none

module hmb_buf_model (
   input  wire logic                  ref_clk,
   input  wire hmb_pkg::hmb_buf_req_s buf_req,
   output logic [7:0]                 rd_data,
   output logic [7:0]                 attr_data
);
   logic [7:0] mem [0:8191];
   logic [7:0] idle_q = 8'h00;

   // Cleared store, so that a read of an unwritten place never returns unknowns.
   initial begin
      for (int i = 0; i < 8192; i++) begin
         mem[i] = 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Writes land at the edge. A read answers in the cycle its request stands, so the
   // engine takes the byte at the edge that ends the request. Outside an answer the
   // lines toggle, so that stale data is never mistaken for a reply.
   always @(posedge ref_clk) begin
      if (buf_req.valid && buf_req.write) begin
         mem[buf_req.addr] <= buf_req.data;
      end
      idle_q <= ~idle_q;
   end
   assign rd_data   = (buf_req.valid && !buf_req.write) ? mem[buf_req.addr] : idle_q;
   assign attr_data = (buf_req.valid && !buf_req.write) ? ~mem[buf_req.addr] : ~idle_q;
endmodule : hmb_buf_model
`default_nettype wire

// *** test/hmb_engine_tb.sv ***
// Self-checking bench for the mailbox command engine.
// Assumes the buffer model beside it and one 40 MHz clock; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none

module hmb_engine_tb;
   logic                  ref_clk, arst_n, mbox_wr, req_wr, flag_wr;
   logic [1:0]            mbox_wr_idx;
   logic [7:0]            mbox_wr_data, buf_rd_data, attr_rd_data, aux_status;
   logic [12:0]           cursor_addr;
   logic                  cu_reset_evt, aux_chg_evt, cursor_load_evt;
   hmb_pkg::hmb_mbox_s    mailbox_q;
   hmb_pkg::hmb_buf_req_s buf_req_q;
   logic [7:0]            flag_reg_q, key_code_q, pen_row_q, pen_field_q, term_type_q, main_stat_q;
   logic                  key_send_q, pen_send_q, por_send_q;
   int                    n_errors = 0, checks_done = 0, n_key = 0, n_pen = 0, n_por = 0;

   hmb_engine hmb_engine_i (.ref_clk(ref_clk), .arst_n(arst_n), .mbox_wr(mbox_wr),
      .mbox_wr_idx(mbox_wr_idx), .mbox_wr_data(mbox_wr_data), .req_wr(req_wr), .flag_wr(flag_wr),
      .buf_rd_data(buf_rd_data), .attr_rd_data(attr_rd_data), .aux_status(aux_status),
      .cursor_addr(cursor_addr), .cu_reset_evt(cu_reset_evt), .aux_chg_evt(aux_chg_evt),
      .cursor_load_evt(cursor_load_evt), .mailbox_q(mailbox_q), .flag_reg_q(flag_reg_q),
      .buf_req_q(buf_req_q), .key_send_q(key_send_q), .key_code_q(key_code_q),
      .pen_send_q(pen_send_q), .pen_row_q(pen_row_q), .pen_field_q(pen_field_q),
      .por_send_q(por_send_q), .term_type_q(term_type_q), .main_stat_q(main_stat_q));

   hmb_buf_model hmb_buf_model_i (.ref_clk(ref_clk), .buf_req(buf_req_q), .rd_data(buf_rd_data),
      .attr_data(attr_rd_data));

   ////////////////////////////////////////////////////////////////////////////
   // Clock at 25 ns and counters of the one-cycle pulses towards the control unit.
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (key_send_q === 1'b1) n_key++;
      if (pen_send_q === 1'b1) n_pen++;
      if (por_send_q === 1'b1) n_por++;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks: compare, mailbox byte write, whole command.
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic put(input logic [1:0] idx, input logic [7:0] val);
      @(negedge ref_clk);
      mbox_wr = 1'b1;
      mbox_wr_idx = idx;
      mbox_wr_data = val;
      @(negedge ref_clk);
      mbox_wr = 1'b0;
   endtask : put

   // Results are in place four edges after the request, so seven cycles leave margin.
   task automatic cmd(input logic [3:0] code, input logic [7:0] r1, r2, r3);
      put(2'd0, {4'h0, code});
      put(2'd1, r1);
      put(2'd2, r2);
      put(2'd3, r3);
      @(negedge ref_clk);
      req_wr = 1'b1;
      @(negedge ref_clk);
      req_wr = 1'b0;
      @(negedge ref_clk);
      chk("request bit", 8'h40, flag_reg_q & 8'h40);
      repeat (5) @(negedge ref_clk);
   endtask : cmd

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios, in the order the status values follow from one another.
   task automatic t_buffer();
      cmd(4'h1, 8'h23, 8'hE1, 8'h5A);
      chk("buffer byte", 8'h5A, hmb_buf_model_i.mem[13'h0123]);
      chk("write status", 8'h20, mailbox_q.reg0);
      chk("request flag", 8'h00, flag_reg_q);
      cmd(4'h0, 8'h23, 8'h01, 8'h00);
      chk("read data", 8'h5A, mailbox_q.reg3);
      chk("read attribute", 8'hA5, mailbox_q.reg2);
      chk("read status", 8'h22, mailbox_q.reg0);
   endtask : t_buffer

   task automatic t_status();
      cmd(4'h2, 8'h00, 8'h00, 8'h00);
      chk("cursor low", 8'hBC, mailbox_q.reg1);
      chk("cursor high", 8'h1A, mailbox_q.reg2);
      chk("aux status", 8'h3C, mailbox_q.reg3);
      @(negedge ref_clk);
      {cu_reset_evt, aux_chg_evt, cursor_load_evt} = 3'b111;
      @(negedge ref_clk);
      {cu_reset_evt, aux_chg_evt, cursor_load_evt} = 3'b000;
      repeat (2) @(negedge ref_clk);
      chk("event status", 8'hAB, main_stat_q);
      cmd(4'h3, 8'h00, 8'h00, 8'h08);
      chk("partial clear", 8'hA3, mailbox_q.reg0);
      cmd(4'h3, 8'h00, 8'h00, 8'hFF);
      chk("full clear", 8'h20, mailbox_q.reg0);
   endtask : t_status

   task automatic t_link();
      int k = n_key;
      int p = n_pen;
      int r = n_por;
      cmd(4'h4, 8'h00, 8'h00, 8'h77);
      chk("key code", 8'h77, key_code_q);
      chk("key pulses", 8'(k + 1), 8'(n_key));
      chk("key status", 8'h00, mailbox_q.reg0);
      cmd(4'h5, 8'h12, 8'h34, 8'h00);
      chk("pen row", 8'h12, pen_row_q);
      chk("pen field", 8'h34, pen_field_q);
      chk("pen pulses", 8'(p + 1), 8'(n_pen));
      cmd(4'h6, 8'h00, 8'h00, 8'h00);
      chk("reset pulses", 8'(r + 1), 8'(n_por));
      chk("reset status", 8'h00, mailbox_q.reg0);
   endtask : t_link

   task automatic t_trigger();
      cmd(4'h8, 8'h50, 8'h00, 8'h00);
      cmd(4'h7, 8'hA0, 8'hF0, 8'h00);
      cmd(4'h1, 8'h51, 8'h00, 8'hAF);
      chk("other address", 8'h00, main_stat_q & 8'h40);
      cmd(4'h1, 8'h50, 8'h00, 8'h5F);
      chk("masked miss", 8'h00, main_stat_q & 8'h40);
      cmd(4'h1, 8'h50, 8'h00, 8'hAF);
      chk("trigger hit", 8'h40, main_stat_q & 8'h40);
      cmd(4'h8, 8'h50, 8'h00, 8'h00);
      chk("trigger cleared", 8'h00, main_stat_q & 8'h40);
   endtask : t_trigger

   task automatic t_attention();
      cmd(4'h3, 8'h00, 8'h00, 8'hFF);
      cmd(4'h9, 8'h00, 8'h00, 8'h02);
      chk("mask status", 8'h00, mailbox_q.reg0);
      chk("no attention", 8'h00, flag_reg_q);
      cmd(4'h1, 8'h00, 8'h01, 8'h00);
      chk("attention set", 8'h80, flag_reg_q);
      @(negedge ref_clk);
      flag_wr = 1'b1;
      @(negedge ref_clk);
      flag_wr = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk("attention cleared", 8'h00, flag_reg_q);
   endtask : t_attention

   task automatic t_info();
      int r = n_por;
      cmd(4'hA, 8'h00, 8'h00, 8'h05);
      chk("new type", 8'h05, term_type_q);
      chk("type reset", 8'(r + 1), 8'(n_por));
      cmd(4'hA, 8'h00, 8'h00, 8'h05);
      chk("same type", 8'(r + 1), 8'(n_por));
      cmd(4'hC, 8'h00, 8'h00, 8'h00);
      chk("attr page", hmb_pkg::ATTR_PAGE, mailbox_q.reg1);
      chk("var page", hmb_pkg::VAR_PAGE, mailbox_q.reg2);
      chk("type read", 8'h05, mailbox_q.reg3);
      cmd(4'hE, 8'h00, 8'h00, 8'h00);
      chk("rev low", hmb_pkg::REV_LO_BCD, mailbox_q.reg1);
      chk("rev high", hmb_pkg::REV_HI_BCD, mailbox_q.reg2);
      chk("oem", hmb_pkg::OEM_NUMBER, mailbox_q.reg3);
      cmd(4'hB, 8'h11, 8'h22, 8'h33);
      chk("undefined status", 8'h02, mailbox_q.reg0);
      chk("undefined reg1", 8'h11, mailbox_q.reg1);
      chk("undefined reg3", 8'h33, mailbox_q.reg3);
      chk("undefined flag", 8'h00, flag_reg_q);
   endtask : t_info

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset for sixteen cycles, then every scenario in turn.
   initial begin
      {arst_n, mbox_wr, req_wr, flag_wr, mbox_wr_idx, mbox_wr_data} = '0;
      {cu_reset_evt, aux_chg_evt, cursor_load_evt} = 3'b000;
      aux_status = 8'h3C;
      cursor_addr = 13'h1ABC;
      repeat (16) @(negedge ref_clk);
      chk("reset status", hmb_pkg::MAIN_STAT_RST, main_stat_q);
      chk("reset flags", 8'h00, flag_reg_q);
      arst_n = 1'b1;
      t_buffer();
      t_status();
      t_link();
      t_trigger();
      t_attention();
      t_info();
      summarize();
   end

   // The run needs well under a thousand cycles; this limit only cuts a hang short.
   initial begin
      repeat (5000) @(posedge ref_clk);
      n_errors++;
      summarize();
   end
endmodule : hmb_engine_tb
`default_nettype wire
